// ---- bench/host_model.sv ----
// Serial host model: drives strobe, serial clock and select, captures serial data.
`timescale 1ns/10ps
module host_model (
	input  wire logic clk_sys,
	input  wire logic sdo_o,
	input  wire logic sdo_oe,
	output logic      convert_strobe,
	output logic      sclk,
	output logic      sdi
);
	logic sdo_line;

	// Released line floats to the pull-up level, never the last bit
	assign sdo_line = sdo_oe ? sdo_o : 1'b1;

	initial begin
		convert_strobe = 1'b0;
		sclk = 1'b0;
		sdi = 1'b1;
	end

	task automatic tick(input int n);
		repeat (n) @(negedge clk_sys);
	endtask : tick

	// Clock and select settle well before the strobe moves
	task automatic pins(input logic s, input logic c, input logic d);
		sclk = c;
		sdi = d;
		tick(4);
		convert_strobe = s;
		tick(4);
	endtask : pins

	// Frame of n clocks, busy flush included; clock stands still outside
	task automatic shift(input int n, input int skip, input logic [17:0] feed, output logic [39:0] got);
		got = '0;
		for (int i = 0; i < n; i++) begin
			sclk = 1'b1;
			sdi = (i >= skip && i < skip + 18) ? feed[17 - (i - skip)] : 1'b1; // upstream bit
			tick(4);
			got = {got[38:0], sdo_line};
			sclk = 1'b0;
			tick(4);
		end
	endtask : shift
endmodule : host_model

// ---- bench/sar_adc_serial_readout_asserts.sv ----
// Port-level checks of the converter serial readout block.
`timescale 1ns/10ps
module sar_adc_serial_readout_asserts (
	input wire logic clk_sys,
	input wire logic rstn,
	input wire logic convert_strobe,
	input wire logic sclk,
	input wire logic sdi,
	input wire logic sdo_o,
	input wire logic sdo_oe,
	input wire logic converting,
	input wire logic shutdown,
	input wire logic chain_mode,
	input wire logic busy_enabled
);
	// ------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rstn);
	logic [5:0] conv_cnt_reg;

	// Clocks spent in the current conversion, cleared while idle
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn)
			conv_cnt_reg <= 6'h00;
		else if (converting)
			conv_cnt_reg <= conv_cnt_reg + 6'h01;
		else
			conv_cnt_reg <= 6'h00;
	end

	// ------------------------------------------------------------
	// Sequences
	// ------------------------------------------------------------
	// Pin edges reach the logic a few clocks late, hence the windows below
	sequence s_cs_rise;
		$rose(convert_strobe) && $past(sdi) && !shutdown;
	endsequence
	sequence s_busy_end;
		$fell(converting) ##1 busy_enabled;
	endsequence
	sequence s_cs_fall;
		$fell(convert_strobe) && sdi && !sclk && !converting && !shutdown;
	endsequence

	// ------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------
	a_conv_len: assert property ($fell(converting) |-> conv_cnt_reg == 6'(sar_readout_pkg::CONV_CYCLES))
		else $error("conversion length differs from the fixed count");
	a_conv_start: assert property ($rose(convert_strobe) && !converting && !shutdown |-> ##[2:6] converting)
		else $error("strobe rise did not start a conversion");
	a_strobe_release: assert property (s_cs_rise |-> ##[2:6] !sdo_oe)
		else $error("serial output still driven after strobe rise");
	a_cs_hiz: assert property (converting && $past(converting, 2) && !chain_mode |-> !sdo_oe)
		else $error("serial output driven during conversion");
	a_busy_low: assert property (s_busy_end |-> sdo_oe && !sdo_o)
		else $error("busy bit not shown low at completion");
	a_cs_msb: assert property (s_cs_fall |-> ##[2:6] sdo_oe)
		else $error("strobe fall did not drive the first bit");
	a_mode_hold: assert property (converting && $past(converting) |-> $stable(chain_mode))
		else $error("interface mode changed during conversion");
	a_chain_drive: assert property (chain_mode && $past(chain_mode) && !shutdown |-> sdo_oe)
		else $error("serial output released in chain mode");
	a_shut_idle: assert property (shutdown |-> !converting)
		else $error("conversion running in shutdown");
	a_shut_enter: assert property ($rose(shutdown) |-> sclk && !convert_strobe)
		else $error("shutdown entered without strobe fall and clock high");
	a_wake_sclk: assert property ($fell(shutdown) |-> !sclk && !convert_strobe)
		else $error("shutdown left without strobe fall and clock low");
endmodule : sar_adc_serial_readout_asserts

bind sar_adc_serial_readout sar_adc_serial_readout_asserts sar_adc_serial_readout_asserts_inst (.clk_sys, .rstn,
	.convert_strobe, .sclk, .sdi, .sdo_o, .sdo_oe, .converting, .shutdown, .chain_mode, .busy_enabled);

// ---- bench/sar_adc_serial_readout_test.sv ----
// Self-checking testbench of the converter serial readout block.
`timescale 1ns/10ps
module sar_adc_serial_readout_test;
	logic        clk_sys = 1'b0;
	logic        rstn = 1'b0;
	logic [17:0] conv_result;
	logic        convert_strobe;
	logic        sclk;
	logic        sdi;
	logic        sdo_o;
	logic        sdo_oe;
	logic        converting;
	logic        shutdown;
	logic        chain_mode;
	logic        busy_enabled;
	logic [31:0] lfsr = 32'hb1dd4ad4;
	logic [39:0] got;
	logic [17:0] res_a;
	logic [17:0] res_b;
	int          failures = 0;
	int          cmp_count = 0;

	always #25 clk_sys = ~clk_sys;

	sar_adc_serial_readout sar_adc_serial_readout_inst (.clk_sys, .rstn, .convert_strobe, .sclk, .sdi,
		.conv_result, .sdo_o, .sdo_oe, .converting, .shutdown, .chain_mode, .busy_enabled);
	host_model host_model_inst (.clk_sys, .sdo_o, .sdo_oe, .convert_strobe, .sclk, .sdi);

	// ------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------
	function automatic logic [31:0] next_rand(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction : next_rand

	task automatic tick(input int n);
		repeat (n) @(negedge clk_sys);
	endtask : tick

	task automatic wrap_up;
		if (failures == 0 && cmp_count > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : wrap_up

	task automatic check(input logic [39:0] seen, input logic [39:0] want);
		cmp_count++;
		if (seen !== want) begin
			failures++;
			$display("ERROR %0t seen %h expected %h", $time, seen, want);
		end
	endtask : check

	// Strobe low first, so reset release never looks like a strobe rise
	task automatic do_reset;
		host_model_inst.pins(1'b0, 1'b0, 1'b1);
		rstn = 1'b0;
		tick(2);
		rstn = 1'b1;
		tick(4);
	endtask : do_reset

	// Bounded wait for a conversion to start and finish
	task automatic wait_done;
		int n;
		n = 0;
		while (converting !== 1'b1 && n < 10) begin
			tick(1);
			n++;
		end
		// A conversion that never starts must not slip through as done
		if (converting !== 1'b1) begin
			failures++;
			$display("ERROR %0t conversion never started", $time);
			wrap_up;
		end
		while (converting !== 1'b0 && n < 50) begin
			tick(1);
			n++;
		end
		if (converting !== 1'b0) begin
			failures++;
			$display("ERROR %0t conversion never ended", $time);
			wrap_up;
		end
		tick(2);
	endtask : wait_done

	// One conversion and full readout; m[1] picks chain, m[0] busy
	task automatic run_mode(input logic [1:0] m, input logic [17:0] r);
		logic [17:0] feed;
		int          n;
		lfsr = next_rand(lfsr);
		feed = m[1] ? lfsr[17:0] : 18'h3ffff;
		n = 18 + int'(m[0]) + (m[1] ? 18 : 0);
		conv_result = r;
		do_reset;
		host_model_inst.pins(1'b0, 1'b0, ~m[1]);
		if (m[1]) check({sdo_oe, sdo_o}, 2'h2);
		host_model_inst.pins(1'b1, m[0] & m[1], ~m[1]);
		check(converting, 1'b1);
		if (m == 2'h1) host_model_inst.pins(1'b0, 1'b0, 1'b1);
		wait_done;
		check({chain_mode, busy_enabled}, m);
		if (m == 2'h0) begin
			check(sdo_oe, 1'b0);
			host_model_inst.pins(1'b0, 1'b0, 1'b1);
		end
		host_model_inst.shift(n, int'(m[0]), feed, got);
		check(got, m[1] ? {4'h0, r, feed} : {22'h0, r});
		tick(4);
		if (!m[1]) check(sdo_oe, 1'b0);
	endtask : run_mode

	// ------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------
	initial begin
		conv_result = 18'h00000;
		tick(2);
		rstn = 1'b1;
		tick(4);
		// All four modes, full-scale and zero codes first
		for (int k = 0; k < 8; k++) begin
			lfsr = next_rand(lfsr);
			run_mode(k[1:0], (k == 0) ? 18'h3ffff : (k == 1) ? 18'h00000 : lfsr[17:0]);
		end
		// Short read leaves bits that lead the next result
		do_reset;
		lfsr = next_rand(lfsr);
		res_a = lfsr[17:0];
		lfsr = next_rand(lfsr);
		res_b = lfsr[17:0];
		conv_result = res_a;
		host_model_inst.pins(1'b1, 1'b0, 1'b1);
		wait_done;
		host_model_inst.pins(1'b0, 1'b0, 1'b1);
		host_model_inst.shift(10, 0, 18'h3ffff, got);
		check(got, {30'h0, res_a[17:8]});
		conv_result = res_b;
		host_model_inst.pins(1'b1, 1'b0, 1'b1);
		wait_done;
		host_model_inst.pins(1'b0, 1'b0, 1'b1);
		host_model_inst.shift(18, 0, 18'h3ffff, got);
		check(got, {22'h0, res_a[7:0], res_b[17:8]});
		// Select tied to strobe: both rise together
		do_reset;
		host_model_inst.pins(1'b0, 1'b0, 1'b0);
		host_model_inst.sdi = 1'b1;
		host_model_inst.convert_strobe = 1'b1;
		wait_done;
		check(chain_mode, 1'b1);
		// Shutdown, ignored strobe rise, then wake
		do_reset;
		host_model_inst.pins(1'b1, 1'b0, 1'b1);
		wait_done;
		host_model_inst.pins(1'b1, 1'b1, 1'b1);
		host_model_inst.pins(1'b0, 1'b1, 1'b1);
		check(shutdown, 1'b1);
		host_model_inst.pins(1'b1, 1'b1, 1'b1);
		check(converting, 1'b0);
		host_model_inst.pins(1'b1, 1'b0, 1'b1);
		host_model_inst.pins(1'b0, 1'b0, 1'b1);
		check(shutdown, 1'b0);
		wrap_up;
	end
endmodule : sar_adc_serial_readout_test

// ---- rtl/edge_find.sv ----
// Edge finder: rising and falling pulses plus the level one cycle earlier.
`timescale 1ns/10ps
module edge_find #(
	parameter int WIDTH = 3
) (
	input  wire logic             clk_sys,
	input  wire logic             rst_n,
	input  wire logic [WIDTH-1:0] level,
	output logic      [WIDTH-1:0] level_prev,
	output logic      [WIDTH-1:0] rise,
	output logic      [WIDTH-1:0] fall
);
	// --------------------------------------------------------
	// Delay by one cycle and compare
	// --------------------------------------------------------
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			level_prev <= '0;
		end else begin
			level_prev <= level;
		end
	end

	assign rise = level & ~level_prev;
	assign fall = ~level & level_prev;
endmodule : edge_find

// ---- rtl/pin_sync.sv ----
// Two-stage synchroniser for a group of asynchronous pins.
`timescale 1ns/10ps
module pin_sync #(
	parameter int WIDTH = 3
) (
	input  wire logic             clk_sys,
	input  wire logic             rst_n,
	input  wire logic [WIDTH-1:0] async_in,
	output logic      [WIDTH-1:0] sync_out
);
	logic [WIDTH-1:0] meta_reg;

	// --------------------------------------------------------
	// Two flops per bit; only the second stage is read
	// --------------------------------------------------------
	genvar i;
	generate
		for (i = 0; i < WIDTH; i++) begin : g_bit
			always_ff @(posedge clk_sys or negedge rst_n) begin
				if (!rst_n) begin
					meta_reg[i] <= 1'b0;
					sync_out[i] <= 1'b0;
				end else begin
					meta_reg[i] <= async_in[i];
					sync_out[i] <= meta_reg[i];
				end
			end
		end
	endgenerate
endmodule : pin_sync

// ---- rtl/sar_adc_serial_readout.sv ----
// Conversion control and serial readout of an 18-bit converter.
`timescale 1ns/10ps
module sar_adc_serial_readout (
	input  wire logic                                 clk_sys,
	input  wire logic                                 rstn,
	input  wire logic                                 convert_strobe,
	input  wire logic                                 sclk,
	input  wire logic                                 sdi,
	input  wire logic [sar_readout_pkg::RESULT_BITS-1:0] conv_result,
	output logic                                      sdo_o,
	output logic                                      sdo_oe,
	output logic                                      converting,
	output logic                                      shutdown,
	output logic                                      chain_mode,
	output logic                                      busy_enabled
);

	// ------------------------------------------------------------
	// State record
	// ------------------------------------------------------------
	typedef struct packed {
		sar_readout_pkg::phase_t                          phase;
		logic [7:0]                                       conv_cnt;
		logic                                             mode_cs;
		logic                                             busy_en;
		logic                                             busy_pend;
		logic [sar_readout_pkg::RESULT_BITS-1:0]          sample;
		logic [sar_readout_pkg::SHIFT_BITS-1:0]           shift;
		logic [5:0]                                       bit_cnt;
		logic [4:0]                                       edge_cnt;
		logic                                             sdo;
		logic                                             sdo_oe;
	} state_t;

	state_t state_reg;
	state_t state_next;

	logic                        rst_meta_reg;
	logic                        rst_sync_reg;
	sar_readout_pkg::link_t      link_sync;
	sar_readout_pkg::link_t      link_prev;
	sar_readout_pkg::link_t      link_rise;
	sar_readout_pkg::link_t      link_fall;
	logic                        cs_select;
	logic                        strobe_fall;
	logic                        strobe_rise;
	logic                        clk_fall;
	logic [4:0]                  edge_limit;

	// ------------------------------------------------------------
	// Reset release
	// ------------------------------------------------------------
	// Asserted at once, released only after two clean clock edges
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			rst_meta_reg <= 1'b0;
			rst_sync_reg <= 1'b0;
		end else begin
			rst_meta_reg <= 1'b1;
			rst_sync_reg <= rst_meta_reg;
		end
	end

	// ------------------------------------------------------------
	// Pin capture
	// ------------------------------------------------------------
	// All three link pins are asynchronous to clk_sys
	pin_sync #(
		.WIDTH (3)
	) u_pin_sync (
		.clk_sys  (clk_sys),
		.rst_n    (rst_sync_reg),
		.async_in ({convert_strobe, sclk, sdi}),
		.sync_out (link_sync)
	);

	edge_find #(
		.WIDTH (3)
	) u_edge_find (
		.clk_sys    (clk_sys),
		.rst_n      (rst_sync_reg),
		.level      (link_sync),
		.level_prev (link_prev),
		.rise       (link_rise),
		.fall       (link_fall)
	);

	assign strobe_rise = link_rise.strobe;
	assign strobe_fall = link_fall.strobe;
	assign clk_fall    = link_fall.sclk;

	// ------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------
	// Keep the unread top bits, append the fresh result right behind them
	function automatic logic [sar_readout_pkg::SHIFT_BITS-1:0] merge_result(
		input logic [sar_readout_pkg::SHIFT_BITS-1:0]  old_bits,
		input logic [5:0]                              unread,
		input logic [sar_readout_pkg::RESULT_BITS-1:0] fresh
	);
		logic [sar_readout_pkg::SHIFT_BITS-1:0] keep_mask;
		logic [sar_readout_pkg::SHIFT_BITS-1:0] placed;
		keep_mask = ~({sar_readout_pkg::SHIFT_BITS{1'b1}} >> unread);
		placed    = {fresh, {sar_readout_pkg::RESULT_BITS{1'b0}}} >> unread;
		return (old_bits & keep_mask) | placed;
	endfunction : merge_result

	// Unread count after a fresh result, saturating at the register size
	function automatic logic [5:0] add_result(input logic [5:0] unread);
		logic [6:0] sum;
		sum = {1'b0, unread} + 7'(sar_readout_pkg::RESULT_BITS);
		if (sum > 7'(sar_readout_pkg::SHIFT_BITS)) begin
			return 6'(sar_readout_pkg::SHIFT_BITS);
		end
		return sum[5:0];
	endfunction : add_result

	// Chip-select readout is open while strobe or serial input is low
	assign cs_select  = ~(link_sync.strobe & link_sync.sdi);
	assign edge_limit = state_reg.busy_en ? sar_readout_pkg::EDGES_BUSY
	                                      : sar_readout_pkg::EDGES_PLAIN;

	// ------------------------------------------------------------
	// Next-state logic
	// ------------------------------------------------------------
	always_comb begin
		state_next = state_reg;
		case (state_reg.phase)
			sar_readout_pkg::ST_ACQUIRE: begin
				if (strobe_rise) begin
					// The level just before the edge is the one latched, so an
					// input wired to the strobe itself reads low
					state_next.mode_cs  = link_prev.sdi;
					state_next.busy_en  = ~link_prev.sdi & link_prev.sclk;
					state_next.sample   = conv_result;
					state_next.conv_cnt = 8'(sar_readout_pkg::CONV_CYCLES - 1);
					state_next.edge_cnt = 5'h00;
					state_next.busy_pend = 1'b0;
					state_next.phase    = sar_readout_pkg::ST_CONVERT;
					if (link_prev.sdi) begin
						state_next.sdo_oe = 1'b0;
					end
				end else if (strobe_fall && link_sync.sclk) begin
					state_next.phase  = sar_readout_pkg::ST_SHUTDOWN;
					state_next.sdo_oe = 1'b0;
				end else if (!state_reg.mode_cs) begin
					// Chain: always driven, shift upstream data in
					state_next.sdo_oe = 1'b1;
					if (clk_fall) begin
						if (state_reg.busy_pend) begin
							state_next.busy_pend = 1'b0;
						end else begin
							// Upstream data enters right behind one result word, so a
							// chain passes it on after 18 clocks and not after 36
							state_next.shift = {state_reg.shift[sar_readout_pkg::SHIFT_BITS-2:0],
							                    1'b0};
							if (state_reg.bit_cnt > 6'(sar_readout_pkg::RESULT_BITS)) begin
								state_next.shift[0] = link_sync.sdi;
							end else begin
								state_next.shift[sar_readout_pkg::SHIFT_BITS-sar_readout_pkg::RESULT_BITS] =
									link_sync.sdi;
							end
							if (state_reg.bit_cnt != 6'h00) begin
								state_next.bit_cnt = state_reg.bit_cnt - 6'h01;
							end
						end
					end
				end else begin
					// Chip-select readout, edges counted per conversion from the strobe rise
					if (clk_fall && cs_select && state_reg.edge_cnt < edge_limit) begin
						state_next.edge_cnt = state_reg.edge_cnt + 5'h01;
						if (state_reg.busy_pend) begin
							state_next.busy_pend = 1'b0;
						end else begin
							state_next.shift = {state_reg.shift[sar_readout_pkg::SHIFT_BITS-2:0],
							                    1'b0};
							if (state_reg.bit_cnt != 6'h00) begin
								state_next.bit_cnt = state_reg.bit_cnt - 6'h01;
							end
						end
					end
					// Released after the last edge or once deselected
					state_next.sdo_oe = cs_select &&
					                    (state_next.edge_cnt < edge_limit);
				end
			end
			sar_readout_pkg::ST_CONVERT: begin
				// Strobe activity is ignored until the count runs out
				if (state_reg.conv_cnt != 8'h00) begin
					state_next.conv_cnt = state_reg.conv_cnt - 8'h01;
				end else begin
					state_next.shift   = merge_result(state_reg.shift, state_reg.bit_cnt,
					                                  state_reg.sample);
					state_next.bit_cnt = add_result(state_reg.bit_cnt);
					state_next.phase   = sar_readout_pkg::ST_ACQUIRE;
					if (state_reg.mode_cs) begin
						state_next.busy_en = ~link_sync.strobe | ~link_sync.sdi;
					end
					if (state_next.busy_en) begin
						state_next.busy_pend = 1'b1;
						state_next.sdo_oe    = 1'b1;
					end else if (!state_reg.mode_cs) begin
						state_next.sdo_oe = 1'b1;
					end else begin
						state_next.sdo_oe = cs_select;
					end
				end
			end
			sar_readout_pkg::ST_SHUTDOWN: begin
				state_next.sdo_oe = 1'b0;
				if (strobe_fall && !link_sync.sclk) begin
					state_next.phase = sar_readout_pkg::ST_ACQUIRE;
				end
			end
			default: begin
				state_next.phase = sar_readout_pkg::ST_ACQUIRE;
			end
		endcase

		// Output bit: busy low, else the head of the register
		state_next.sdo = state_next.busy_pend ? 1'b0
		                 : state_next.shift[sar_readout_pkg::SHIFT_BITS-1];

		// Both low outside conversion and shutdown: drive low for the chain
		if (!link_sync.strobe && !link_sync.sdi &&
		    state_next.phase == sar_readout_pkg::ST_ACQUIRE) begin
			state_next.sdo    = 1'b0;
			state_next.sdo_oe = 1'b1;
		end
	end

	// ------------------------------------------------------------
	// State register
	// ------------------------------------------------------------
	// Within a readout the output bit only moves on sampled falling edges, so it is
	// stable around every rising edge the host may sample on
	always_ff @(posedge clk_sys or negedge rst_sync_reg) begin
		if (!rst_sync_reg) begin
			state_reg.phase     <= sar_readout_pkg::ST_ACQUIRE;
			state_reg.conv_cnt  <= 8'h00;
			state_reg.mode_cs   <= 1'b1;
			state_reg.busy_en   <= 1'b0;
			state_reg.busy_pend <= 1'b0;
			state_reg.sample    <= '0;
			state_reg.shift     <= sar_readout_pkg::SHIFT_RESET;
			state_reg.bit_cnt   <= sar_readout_pkg::COUNT_RESET;
			state_reg.edge_cnt  <= 5'h00;
			state_reg.sdo       <= 1'b0;
			state_reg.sdo_oe    <= 1'b0;
		end else begin
			state_reg <= state_next;
		end
	end

	// ------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------
	assign sdo_o        = state_reg.sdo;
	assign sdo_oe       = state_reg.sdo_oe;
	assign converting   = (state_reg.phase == sar_readout_pkg::ST_CONVERT);
	assign shutdown     = (state_reg.phase == sar_readout_pkg::ST_SHUTDOWN);
	assign chain_mode   = ~state_reg.mode_cs;
	assign busy_enabled = state_reg.busy_en;

endmodule : sar_adc_serial_readout

// ---- rtl/sar_readout_pkg.sv ----
// Constants and shared types of the converter serial readout block.
// Behaviour
// - Latch serial input at each strobe rising edge to pick the interface mode.
// - Serial input high picks chip-select mode, low picks daisy-chain mode.
// - Serial input tied to the strobe gives daisy-chain mode.
// - Three-wire use needs only strobe, serial clock and serial output.
// - Four-wire readout is gated by serial input as select, apart from strobe.
// - Busy bit marks end of conversion; one extra clock flushes it first.
// - Chip-select mode enables busy if strobe or serial input low at completion.
// - Daisy-chain mode takes busy enable from serial clock at strobe rise.
// - Output bits hold across both clock edges; host captures on falling edge.
// - Unread bits are kept and shifted out first in the next cycle.
// - Strobe falling while serial clock high enters shutdown.
// - Strobe falling while serial clock low leaves shutdown.
// - Three-wire chip-select: strobe rise starts conversion, output goes high impedance.
// - A started conversion completes whatever the strobe does.
// - After conversion acquire again; falling strobe drives the first result bit.
// - Bits shift on falling clock edges; output released after 18th edge or strobe high.
// - Daisy-chain mode shifts serial input into the register on falling edges.
// - Serial input and strobe both low drive the output low.
// - With busy enabled, completion drives the output from high impedance to low.
package sar_readout_pkg;

	// ------------------------------------------------------------
	// Widths and timing
	// ------------------------------------------------------------
	localparam int RESULT_BITS  = 18;
	localparam int SHIFT_BITS   = 2 * RESULT_BITS;
	localparam int CLK_PERIOD_NS = 50;
	localparam int CONV_TIME_NS  = 1000;
	localparam int CONV_CYCLES   = (CONV_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int QUIET_BEFORE_STROBE_TIME_NS = 25;
	localparam int QUIET_AFTER_STROBE_TIME_NS  = 10;
	localparam int QUIET_BEFORE_CYCLES =
		(QUIET_BEFORE_STROBE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int QUIET_AFTER_CYCLES =
		(QUIET_AFTER_STROBE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam logic [4:0] EDGES_PLAIN = 5'h12;
	localparam logic [4:0] EDGES_BUSY  = 5'h13;

	// ------------------------------------------------------------
	// Reset values
	// ------------------------------------------------------------
	localparam logic [SHIFT_BITS-1:0] SHIFT_RESET = '0;
	localparam logic [5:0]            COUNT_RESET = 6'h00;

	// ------------------------------------------------------------
	// Types
	// ------------------------------------------------------------
	typedef enum logic [1:0] {
		ST_ACQUIRE  = 2'b00,
		ST_CONVERT  = 2'b01,
		ST_SHUTDOWN = 2'b10
	} phase_t;

	// Link pin levels after synchronisation
	typedef struct packed {
		logic strobe;
		logic sclk;
		logic sdi;
	} link_t;

endpackage : sar_readout_pkg
